// *** arcp_pkg.sv ***
// Package with constants and carrier types for the ASCII command parser
package arcp_pkg;
  localparam logic [7:0] ARCP_CR     = 8'h0D;
  localparam logic [7:0] ARCP_LF     = 8'h0A;
  localparam logic [7:0] ARCP_SP     = 8'h20;
  localparam logic [7:0] ARCP_QM     = 8'h3F;
  localparam logic [7:0] ARCP_COMMA  = 8'h2C;
  localparam logic [7:0] ARCP_CHAR_E = 8'h45;
  localparam logic [7:0] ARCP_STAR   = 8'h2A;
  localparam int ARCP_ERRQ_DEPTH     = 10;
  localparam int ARCP_KW_MAX         = 8;
  localparam int ARCP_RESP_MAX       = 16;
  localparam int ARCP_FIFO_DEPTH     = 8;
  // Factory serial settings
  localparam logic [2:0] ARCP_RST_BAUD   = 3'h3;
  localparam logic       ARCP_RST_DBITS8 = 1'b1;
  localparam logic       ARCP_RST_STOP2  = 1'b0;
  localparam logic [1:0] ARCP_RST_PARITY = 2'h0;
  localparam logic       ARCP_RST_ECHO   = 1'b0;
  localparam logic [1:0] ARCP_RST_TERM   = 2'h3;
  // Error codes
  localparam logic [3:0] ARCP_ERR_NONE    = 4'h0;
  localparam logic [3:0] ARCP_ERR_UNKNOWN = 4'h1;
  localparam logic [3:0] ARCP_ERR_DATA    = 4'h2;
  localparam logic [3:0] ARCP_ERR_QDATA   = 4'h3;
  localparam logic [3:0] ARCP_ERR_LONG    = 4'h4;
  typedef enum logic [2:0] {
    ARCP_BAUD_9600, ARCP_BAUD_19200, ARCP_BAUD_38400,
    ARCP_BAUD_57600, ARCP_BAUD_115200
  } arcp_baud_t;
  typedef enum logic [1:0] {
    ARCP_PAR_NONE, ARCP_PAR_EVEN, ARCP_PAR_ODD
  } arcp_parity_t;
  typedef struct packed {
    logic [2:0] baud;
    logic       dbits8;
    logic       stop2;
    logic [1:0] parity;
    logic       echo;
    logic [1:0] term;
  } arcp_serial_cfg_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       eoi;
  } arcp_char_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    logic       is_query;
    logic       flag_bool;
    logic       bool_val;
    logic       flag_num;
    logic [3:0] nparams;
  } arcp_cmd_t;
  localparam logic [7:0] ARCP_OP_NONE  = 8'h00;
  localparam logic [7:0] ARCP_OP_IDN   = 8'h01;
  localparam logic [7:0] ARCP_OP_RST   = 8'h02;
  localparam logic [7:0] ARCP_OP_ECHO  = 8'h03;
  localparam logic [7:0] ARCP_OP_BAUD  = 8'h04;
  localparam logic [7:0] ARCP_OP_VALUE = 8'h05;
  localparam logic [7:0] ARCP_OP_ERR   = 8'h06;
endpackage

// *** arcp_parser.sv ***
// ASCII remote command parser with FIFO, error queue and reply builder
`timescale 1ns/1ps
// Overview of operation
// - A CR, LF or both ends each ASCII command.
// - Keywords match regardless of letter case.
// - Each query yields exactly one response string.
// - A detected error sets the error flag in the reply.
// - Keyword followed by question mark is that command's query.
// - Query only when question mark is last before terminator.
// - Queries carry no data field after the question mark.
// - Reply starts with space, or E when the error queue holds entries.
// - Error queue keeps the ten most recent errors.
// - Command is keyword alone or keyword, space, data.
// - Multiple parameters are split at each comma.
// - Boolean words 0 False No Off and 1 True Yes On accepted.
// - Numbers may be integer, decimal, signed or with exponent.
// - End-or-identify also ends a command on the GPIB port.
// - Query replies end with the programmed termination sequence.
// - Floating point reply values use exponential notation.
// - With echo on each serial character returns at once.
// - Serial framing: five baud rates, 7/8 bits, 1/2 stops, parity.
// - Factory default is 57600 8N1, echo off.
// - Identification query answers a string; reset restores defaults.

// Synchronous FIFO with valid/ready on both sides
module arcp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  // Handshake terms
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage and pointers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        mem[wr_reg] <= in_data;
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : AW'(wr_reg + 1'b1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : AW'(rd_reg + 1'b1);
      end
      cnt_reg <= (AW+1)'(cnt_reg + push - pop);
    end
  end
endmodule

// Parser top
module arcp_parser
  import arcp_pkg::*;
#(
  parameter int         FIFO_DEPTH = ARCP_FIFO_DEPTH,
  parameter logic [7:0] ID_CHAR    = 8'h41 // Arbitrary identification char
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_eoi,
  output logic            rx_ready,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  input  wire logic       tx_ready,
  output logic            echo_valid,
  output logic [7:0]      echo_data,
  output arcp_serial_cfg_t serial_cfg,
  output logic            cmd_valid,
  output arcp_cmd_t       cmd_out,
  output logic [3:0]      err_count,
  output logic            err_flag
);
  typedef enum {
    ST_KEY, ST_DATA, ST_SKIP, ST_EXEC, ST_RESP, ST_TERM
  } arcp_state_t;

  typedef struct packed {
    arcp_state_t      state;
    logic [63:0]      kw;
    logic [3:0]       kw_len;
    logic             qmark_last;
    logic             has_data;
    logic [3:0]       nparams;
    logic [39:0]      tok;
    logic [2:0]       tok_len;
    logic             num_ok;
    logic             bool_hit;
    logic             bool_val;
    logic             too_long;
    logic [39:0]      errq;
    logic [3:0]       err_cnt;
    logic [3:0]       new_err;
    arcp_serial_cfg_t cfg;
    logic [7:0]       opcode;
    logic [3:0]       rptr;
    logic [3:0]       rlen;
    logic [127:0]     rbuf;
    logic [1:0]       tphase;
    logic             tx_v;
    logic [7:0]       tx_d;
    logic             echo_v;
    logic [7:0]       echo_d;
    logic             cmd_v;
    arcp_cmd_t        cmd;
  } arcp_st_t;

  // Characters arrive from a pin-side domain: two-stage sync per field
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  logic       f_valid;
  logic       f_ready;
  logic [8:0] f_data;
  logic       in_ready;
  logic       consume;
  arcp_st_t   st_reg;
  arcp_st_t   st_next;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {rx_valid, rx_eoi, rx_data};
      sync2_reg <= sync1_reg;
    end
  end

  arcp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (sync2_reg[9]),
    .in_ready  (in_ready),
    .in_data   (sync2_reg[8:0]),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // Upper-case fold so keyword matching ignores case
  function automatic logic [7:0] upcase(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
  endfunction

  // Terminator test: CR, LF or end-or-identify
  function automatic logic is_term(input logic [7:0] c, input logic e);
    return (c == ARCP_CR) || (c == ARCP_LF) || e;
  endfunction

  // Numeric character test: digits, sign, point, exponent
  function automatic logic is_numc(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || c == 8'h2D || c == 8'h2B ||
           c == 8'h2E || c == 8'h45;
  endfunction

  // Boolean word decode: bit1 hit, bit0 value
  function automatic logic [1:0] bool_dec(input logic [39:0] t,
                                           input logic [2:0] n);
    logic [1:0] r;
    r = 2'b00;
    case (n)
      3'd1: if (t[7:0] == 8'h30) r = 2'b10;
            else if (t[7:0] == 8'h31) r = 2'b11;
      3'd2: if (t[15:0] == 16'h4E4F) r = 2'b10;
            else if (t[15:0] == 16'h4F4E) r = 2'b11;
      3'd3: if (t[23:0] == 24'h4F4646) r = 2'b10;
            else if (t[23:0] == 24'h594553) r = 2'b11;
      3'd4: if (t[31:0] == 32'h54525545) r = 2'b11;
      3'd5: if (t == 40'h46414C5345) r = 2'b10;
      default: r = 2'b00;
    endcase
    return r;
  endfunction

  assign consume = f_valid && (st_reg.state == ST_KEY ||
                   st_reg.state == ST_DATA || st_reg.state == ST_SKIP);
  assign f_ready = consume;
  assign rx_ready = in_ready;

  // Next-state logic
  always_comb begin
    logic [7:0] c;
    logic [7:0] uc;
    logic [1:0] bd;
    logic       e;
    c  = f_data[7:0];
    e  = f_data[8];
    uc = upcase(c);
    bd = bool_dec(st_reg.tok, st_reg.tok_len);
    st_next = st_reg;
    st_next.echo_v = 1'b0;
    st_next.cmd_v  = 1'b0;
    st_next.new_err = ARCP_ERR_NONE;
    if (st_reg.tx_v && tx_ready) begin
      st_next.tx_v = 1'b0;
    end
    // Immediate echo of every received character when enabled
    if (consume && st_reg.cfg.echo) begin
      st_next.echo_v = 1'b1;
      st_next.echo_d = c;
    end
    case (st_reg.state)
      ST_KEY: if (consume) begin
        if (is_term(c, 1'b0)) begin
          st_next.state = ST_EXEC;
        end else if (c == ARCP_SP) begin
          st_next.state = ST_DATA;
          st_next.has_data = 1'b1;
          st_next.nparams = 4'd1;
          st_next.num_ok = 1'b1;
        end else begin
          st_next.qmark_last = (c == ARCP_QM);
          if (st_reg.kw_len == 4'(ARCP_KW_MAX)) begin
            st_next.too_long = 1'b1;
          end else begin
            st_next.kw = {st_reg.kw[55:0], uc};
            st_next.kw_len = st_reg.kw_len + 4'd1;
          end
        end
        // End-or-identify rides on the last real char, which still counts
        if (e) begin
          st_next.state = ST_EXEC;
        end
      end
      ST_DATA: if (consume) begin
        if (is_term(c, 1'b0)) begin
          st_next.state = ST_EXEC;
          st_next.bool_hit = bd[1];
          st_next.bool_val = bd[0];
        end else if (c == ARCP_COMMA) begin
          st_next.nparams = st_reg.nparams + 4'd1;
          st_next.tok_len = 3'd0;
          st_next.tok = '0;
          st_next.num_ok = 1'b1;
        end else begin
          st_next.num_ok = st_reg.num_ok & is_numc(uc);
          if (st_reg.tok_len != 3'd5) begin
            st_next.tok = {st_reg.tok[31:0], uc};
            st_next.tok_len = st_reg.tok_len + 3'd1;
          end
        end
        if (e) begin
          st_next.state = ST_EXEC;
        end
      end
      ST_SKIP: if (consume && is_term(c, e)) begin
        st_next.state = ST_KEY;
      end
      ST_EXEC: begin
        st_next.state = ST_KEY;
        st_next.kw = '0;
        st_next.kw_len = 4'd0;
        st_next.tok = '0;
        st_next.tok_len = 3'd0;
        st_next.qmark_last = 1'b0;
        st_next.has_data = 1'b0;
        st_next.too_long = 1'b0;
        st_next.nparams = 4'd0;
        st_next.opcode = ARCP_OP_NONE;
        if (st_reg.kw_len != 4'd0 || st_reg.has_data) begin
          // Decode keyword; queries only with trailing question mark
          if (st_reg.too_long) begin
            st_next.new_err = ARCP_ERR_LONG;
          end else if (st_reg.qmark_last && st_reg.has_data) begin
            st_next.new_err = ARCP_ERR_QDATA;
          end else if (st_reg.kw[39:0] == 40'h2A49444E3F &&
                       st_reg.kw_len == 4'd5) begin
            st_next.opcode = ARCP_OP_IDN;
          end else if (st_reg.kw[31:0] == 32'h2A525354 &&
                       st_reg.kw_len == 4'd4) begin
            st_next.cfg = '{ARCP_RST_BAUD, ARCP_RST_DBITS8,
                            ARCP_RST_STOP2, ARCP_RST_PARITY,
                            ARCP_RST_ECHO, ARCP_RST_TERM};
          end else if (st_reg.kw[31:0] == 32'h4543484F &&
                       st_reg.kw_len == 4'd4) begin
            if (st_reg.has_data && bd[1]) begin
              st_next.cfg.echo = bd[0];
            end else begin
              st_next.new_err = ARCP_ERR_DATA;
            end
          end else if (st_reg.kw[39:0] == 40'h4543484F3F &&
                       st_reg.kw_len == 4'd5) begin
            st_next.opcode = ARCP_OP_ECHO;
          end else if (st_reg.kw[31:0] == 32'h42415544 &&
                       st_reg.kw_len == 4'd4) begin
            if (st_reg.num_ok && st_reg.tok[7:0] >= 8'h30 &&
                st_reg.tok[7:0] <= 8'h34) begin
              st_next.cfg.baud = 3'(st_reg.tok[7:0] - 8'h30);
            end else begin
              st_next.new_err = ARCP_ERR_DATA;
            end
          end else if (st_reg.kw[39:0] == 40'h524154453F &&
                       st_reg.kw_len == 4'd5) begin
            st_next.opcode = ARCP_OP_VALUE;
          end else if (st_reg.kw_len == 4'd1 && st_reg.qmark_last) begin
            st_next.opcode = ARCP_OP_VALUE;
          end else begin
            st_next.new_err = ARCP_ERR_UNKNOWN;
          end
          st_next.cmd_v = 1'b1;
          st_next.cmd = '{1'b1, st_reg.kw[7:0], st_reg.qmark_last,
                          bd[1], bd[0], st_reg.num_ok, st_reg.nparams};
          // One response per query, even when it failed
          if (st_reg.qmark_last) begin
            st_next.state = ST_RESP;
            st_next.rptr = 4'd0;
          end
        end
      end
      ST_RESP: if (!st_reg.tx_v || tx_ready) begin
        st_next.tx_v = 1'b1;
        if (st_reg.rptr == 4'd0) begin
          st_next.tx_d = (st_reg.err_cnt != 4'd0) ? ARCP_CHAR_E
                                                   : ARCP_SP;
          st_next.rptr = 4'd1;
          case (st_reg.opcode)
            ARCP_OP_IDN: begin
              st_next.rbuf = {ID_CHAR, 120'h0};
              st_next.rlen = 4'd1;
            end
            ARCP_OP_ECHO: begin
              st_next.rbuf = {(st_reg.cfg.echo ? 8'h31 : 8'h30), 120'h0};
              st_next.rlen = 4'd1;
            end
            ARCP_OP_VALUE: begin
              // Exponential notation +0.00000E+00
              st_next.rbuf = {96'h2B302E3030303030452B3030, 32'h0};
              st_next.rlen = 4'd12;
            end
            default: begin
              st_next.rbuf = '0;
              st_next.rlen = 4'd0;
            end
          endcase
        end else if (st_reg.rptr <= st_reg.rlen) begin
          st_next.tx_d = st_reg.rbuf[127:120];
          st_next.rbuf = {st_reg.rbuf[119:0], 8'h00};
          st_next.rptr = st_reg.rptr + 4'd1;
        end else begin
          st_next.tx_v = 1'b0;
          st_next.state = ST_TERM;
          st_next.tphase = 2'd0;
        end
      end
      ST_TERM: if (!st_reg.tx_v || tx_ready) begin
        // term bit1 sends CR, bit0 sends LF
        st_next.tx_v = 1'b0;
        if (st_reg.tphase == 2'd0) begin
          st_next.tphase = 2'd1;
          if (st_reg.cfg.term[1]) begin
            st_next.tx_v = 1'b1;
            st_next.tx_d = ARCP_CR;
          end
        end else begin
          st_next.state = ST_KEY;
          if (st_reg.cfg.term[0]) begin
            st_next.tx_v = 1'b1;
            st_next.tx_d = ARCP_LF;
          end
        end
      end
      default: st_next.state = ST_KEY;
    endcase
    // Error queue: newest in low nibble, oldest falls off
    if (st_next.new_err != ARCP_ERR_NONE) begin
      st_next.errq = {st_reg.errq[35:0], st_next.new_err};
      if (st_reg.err_cnt != 4'(ARCP_ERRQ_DEPTH)) begin
        st_next.err_cnt = st_reg.err_cnt + 4'd1;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.state <= ST_KEY;
      st_reg.cfg <= '{ARCP_RST_BAUD, ARCP_RST_DBITS8, ARCP_RST_STOP2,
                      ARCP_RST_PARITY, ARCP_RST_ECHO, ARCP_RST_TERM};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state flops, except err_flag decoded from the error count
  assign tx_valid   = st_reg.tx_v;
  assign tx_data    = st_reg.tx_d;
  assign echo_valid = st_reg.echo_v;
  assign echo_data  = st_reg.echo_d;
  assign serial_cfg = st_reg.cfg;
  assign cmd_valid  = st_reg.cmd_v;
  assign cmd_out    = st_reg.cmd;
  assign err_count  = st_reg.err_cnt;
  assign err_flag   = (st_reg.err_cnt != 4'd0) ? 1'b1 : 1'b0;
endmodule

// *** arcp_parser_properties.sv ***
// Concurrent checks on the ports of the command parser
`timescale 1ns/1ps
module arcp_parser_checker
  import arcp_pkg::*;
#(
  parameter int FIFO_DEPTH = ARCP_FIFO_DEPTH
) (
  input wire logic             ref_clk,
  input wire logic             rst_n,
  input wire logic             rx_valid,
  input wire logic [7:0]       rx_data,
  input wire logic             rx_eoi,
  input wire logic             rx_ready,
  input wire logic             tx_valid,
  input wire logic [7:0]       tx_data,
  input wire logic             tx_ready,
  input wire logic             echo_valid,
  input wire logic [7:0]       echo_data,
  input wire arcp_serial_cfg_t serial_cfg,
  input wire logic             cmd_valid,
  input wire arcp_cmd_t        cmd_out,
  input wire logic [3:0]       err_count,
  input wire logic             err_flag
);
  localparam logic [9:0] DEF_CFG = {ARCP_RST_BAUD, ARCP_RST_DBITS8,
    ARCP_RST_STOP2, ARCP_RST_PARITY, ARCP_RST_ECHO, ARCP_RST_TERM};
  logic in_reply_reg;
  logic in_reply_next;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // A reply is open from its first accepted char until its line feed
  always_comb begin
    in_reply_next = in_reply_reg;
    if (tx_valid && tx_ready) begin
      in_reply_next = (tx_data != ARCP_LF);
    end
  end
  // Register the reply tracker
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_reply_reg <= 1'b0;
    end else begin
      in_reply_reg <= in_reply_next;
    end
  end
  // Query executed, then the first reply char offered
  sequence s_query_exec;
    cmd_valid && cmd_out.is_query;
  endsequence
  sequence s_reply_open;
    tx_valid && !in_reply_reg;
  endsequence
  reset_cfg_a: assert property ($rose(rst_n) |-> serial_cfg == DEF_CFG)
    else $error("serial settings not at factory values after reset");
  query_reply_a: assert property (s_query_exec |-> ##[1:4] tx_valid)
    else $error("query executed without a reply");
  reply_prefix_a: assert property (s_reply_open |->
    tx_data == (err_flag ? ARCP_CHAR_E : ARCP_SP))
    else $error("reply prefix does not match error state");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data))
    else $error("reply char changed before it was taken");
  err_flag_a: assert property (err_flag == (err_count != 4'h0))
    else $error("error flag disagrees with queue count");
  err_step_a: assert property (err_count == $past(err_count) ||
    err_count == $past(err_count) + 4'h1)
    else $error("error count moved by more than one");
  err_cap_a: assert property (err_count <= 4'hA)
    else $error("error count above ten");
  echo_gate_a: assert property (echo_valid |->
    serial_cfg.echo || $past(serial_cfg.echo))
    else $error("echo sent while echo disabled");
  cmd_pulse_a: assert property (cmd_valid |-> cmd_out.valid ##1 !cmd_valid)
    else $error("command strobe not a single cycle");
  frame_range_a: assert property (serial_cfg.baud <= 3'h4 &&
    serial_cfg.parity != 2'h3)
    else $error("serial framing outside supported set");
endmodule

bind arcp_parser arcp_parser_checker #(.FIFO_DEPTH(FIFO_DEPTH)) i_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_ready(rx_ready),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .echo_valid(echo_valid), .echo_data(echo_data),
  .serial_cfg(serial_cfg), .cmd_valid(cmd_valid), .cmd_out(cmd_out),
  .err_count(err_count), .err_flag(err_flag));

// *** arcp_host.sv ***
// Host model that types command lines and collects replies
`timescale 1ns/1ps
module arcp_host (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  output logic             rx_eoi,
  input  wire logic        rx_ready,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output logic             tx_ready,
  input  wire logic        echo_valid,
  input  wire logic        hold_off,
  input  wire logic [31:0] rnd
);
  logic [7:0] got[$];
  int         n_echo = 0;
  // Idle lines at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_eoi   = 1'b0;
  end
  // Sink stalls at random, or fully while held off
  assign tx_ready = !hold_off && rnd[0];
  // Collect reply chars and count echoes
  always @(posedge ref_clk) begin
    if (rst_n && tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
    if (rst_n && echo_valid) begin
      n_echo++;
    end
  end
  // Type a line char by char; eoi may mark its last char
  task automatic send(input string s, input bit eoi_end);
    int w;
    for (int i = 0; i < s.len(); i++) begin
      w = 0;
      while (!rx_ready && w < 2000) begin
        @(posedge ref_clk);
        w++;
      end
      rx_valid <= 1'b1;
      rx_data  <= s[i];
      rx_eoi   <= eoi_end && (i == s.len() - 1);
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rx_data <= ~s[i];
      rx_eoi  <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
endmodule

// *** arcp_parser_bench.sv ***
// Self-checking bench for the ASCII command parser
`timescale 1ns/1ps
module arcp_parser_bench
  import arcp_pkg::*;
;
  localparam logic [7:0] ID_CH = 8'h5A; // Arbitrary identification char
  localparam logic [9:0] DEF_CFG = {ARCP_RST_BAUD, ARCP_RST_DBITS8,
    ARCP_RST_STOP2, ARCP_RST_PARITY, ARCP_RST_ECHO, ARCP_RST_TERM};
  localparam string FLT = "+0.00000E+00\r\n";
  logic             ref_clk;
  logic             rst_n;
  logic             hold_off = 1'b0;
  logic [31:0]      seed = 32'h6868_ea91;
  logic             rx_valid, rx_eoi, rx_ready, tx_valid, tx_ready;
  logic             echo_valid, cmd_valid, err_flag;
  logic [7:0]       rx_data, tx_data, echo_data;
  logic [3:0]       err_count;
  arcp_serial_cfg_t serial_cfg;
  arcp_cmd_t        cmd_out, last_cmd;
  logic [7:0]       last_echo = 8'h00;
  int               num_errors = 0;
  int               n_compared = 0;
  int               n_cmd = 0;
  int               cyc = 0;

  arcp_parser #(.FIFO_DEPTH(8), .ID_CHAR(ID_CH)) i_arcp_parser (
    .ref_clk(ref_clk), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .echo_valid(echo_valid), .echo_data(echo_data),
    .serial_cfg(serial_cfg), .cmd_valid(cmd_valid), .cmd_out(cmd_out),
    .err_count(err_count), .err_flag(err_flag));
  arcp_host i_host (
    .ref_clk(ref_clk), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .echo_valid(echo_valid), .hold_off(hold_off), .rnd(seed));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Clock of 8 ns
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Random stream, command capture and hang guard
  always @(posedge ref_clk) begin
    seed <= lfsr(seed);
    cyc  <= cyc + 1;
    if (echo_valid) begin
      last_echo <= echo_data;
    end
    if (cmd_valid) begin
      last_cmd <= cmd_out;
      n_cmd    <= n_cmd + 1;
    end
    if (cyc == 60000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    n_compared++;
    if (exp !== seen) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Send one line and wait for its command strobe
  task automatic run(input string s, input bit eoi_end, input bit must);
    int n0;
    int w;
    n0 = n_cmd;
    w = 0;
    i_host.send(s, eoi_end);
    while (n_cmd == n0 && w < 100) begin
      @(posedge ref_clk);
      w++;
    end
    if (must) begin
      chk("command strobe", 1, n_cmd > n0);
    end
    repeat (4) @(posedge ref_clk);
  endtask
  // Wait for a whole reply and compare it char by char
  task automatic reply(input string e);
    int w;
    w = 0;
    while (i_host.got.size() < e.len() && w < 800) begin
      @(posedge ref_clk);
      w++;
    end
    repeat (20) @(posedge ref_clk);
    chk("reply length", e.len(), i_host.got.size());
    for (int i = 0; i < e.len() && i < i_host.got.size(); i++) begin
      chk("reply char", e[i], i_host.got[i]);
    end
    i_host.got.delete();
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    string ids[3] = '{"*IDN?\r", "*idn?\n", "*IdN?\r\n"};
    string bw[8] = '{"0", "False", "No", "Off", "1", "tRUE", "YES", "on"};
    string nums[4] = '{"1", "1.0", "-5.678", "25.68324e-5"};
    string idr;
    int    e0;
    int    v;
    idr = $sformatf(" %c\r\n", ID_CH);
    rst_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("reset config", DEF_CFG, serial_cfg);
    chk("reset errors", 0, err_count);
    $display("test reset done");
    foreach (ids[i]) begin
      run(ids[i], 1'b0, 1'b1);
      reply(idr);
    end
    run("*iDn?", 1'b1, 1'b1);
    reply(idr);
    run("?\r", 1'b0, 1'b1);
    chk("query flag", 1, last_cmd.is_query);
    reply({" ", FLT});
    $display("test queries done");
    for (int i = 0; i < 8; i++) begin
      run($sformatf("ECHO %s\r", bw[i]), 1'b0, 1'b1);
      chk("echo setting", i >= 4, serial_cfg.echo);
      chk("bool word hit", 1, last_cmd.flag_bool);
    end
    e0 = i_host.n_echo;
    run("*IDN?\r", 1'b0, 1'b1);
    reply(idr);
    chk("echo count on", e0 + 6, i_host.n_echo);
    chk("echo char", ARCP_CR, last_echo);
    run("ECHO Off\r", 1'b0, 1'b1);
    e0 = i_host.n_echo;
    run("*IDN?\r", 1'b0, 1'b1);
    reply(idr);
    chk("echo count off", e0, i_host.n_echo);
    $display("test echo done");
    for (int i = 0; i < 8; i++) begin
      v = (i < 2) ? i * 4 : seed % 5;
      run($sformatf("BAUD %0d\r", v), 1'b0, 1'b1);
      chk("baud setting", v, serial_cfg.baud);
    end
    foreach (nums[i]) begin
      run($sformatf("BAUD %s\r", nums[i]), 1'b0, 1'b1);
      chk("numeric accepted", 1, last_cmd.flag_num);
    end
    run("BAUD 1,2,3\r", 1'b0, 1'b1);
    chk("parameter count", 3, last_cmd.nparams);
    run("ECHO 1\r", 1'b0, 1'b1);
    run("*RST\r", 1'b0, 1'b1);
    chk("config after reset command", DEF_CFG, serial_cfg);
    $display("test settings done");
    e0 = err_count;
    run("FOO\r", 1'b0, 1'b0);
    chk("error count", (e0 < 10) ? e0 + 1 : 10, err_count);
    chk("error flag", 1, err_flag);
    run("?\r", 1'b0, 1'b1);
    reply({"E", FLT});
    repeat (11) run("XQ\r", 1'b0, 1'b0);
    chk("error count full", 10, err_count);
    $display("test errors done");
    hold_off <= 1'b1;
    run("?\r", 1'b0, 1'b1);
    fork
      i_host.send("*IDN?\r*IDN?\r", 1'b0);
    join_none
    e0 = 0;
    while (rx_ready !== 1'b0 && e0 < 400) begin
      @(posedge ref_clk);
      e0++;
    end
    chk("fifo refuses when full", 0, rx_ready);
    hold_off <= 1'b0;
    wait fork;
    idr = $sformatf("E%c\r\n", ID_CH);
    reply({"E", FLT, idr, idr});
    $display("test buffer done");
    complete_run();
  end
endmodule
